// File: core/vtpg_pkg.sv
/*
 * vtpg_pkg: register map, indirect field layout, pattern codes, timing
 * constants and the pixel carrier type of the video test pattern generator.
 * Assumes a single 250 MHz core clock and 8-bit register accesses.
 */
`default_nettype none
package vtpg_pkg;
   localparam logic [7:0] REG_IND_ADDR = 8'h66;
   localparam logic [7:0] REG_IND_DATA = 8'h67;
   localparam int IND_RW_DEPTH = 24;
   localparam logic [4:0] IX_CTL = 5'h00;
   localparam logic [4:0] IX_CFG = 5'h01;
   localparam logic [4:0] IX_RED = 5'h02;
   localparam logic [4:0] IX_GRN = 5'h03;
   localparam logic [4:0] IX_BLU = 5'h04;
   localparam logic [4:0] IX_SCR_FRAMES = 5'h05;
   localparam logic [4:0] IX_SCR_COUNT = 5'h06;
   localparam logic [4:0] IX_ORDER = 5'h08;
   localparam logic [4:0] IX_HACT = 5'h10;
   localparam logic [4:0] IX_HTOT = 5'h12;
   localparam logic [4:0] IX_VACT = 5'h14;
   localparam logic [4:0] IX_VTOT = 5'h16;
   localparam logic [4:0] IX_ST_WL = 5'h18;
   localparam logic [4:0] IX_ST_WH = 5'h19;
   localparam logic [4:0] IX_ST_HL = 5'h1A;
   localparam logic [4:0] IX_ST_HH = 5'h1B;
   localparam logic [4:0] IX_ST_SLOT = 5'h1C;
   localparam int CTL_INV = 5;
   localparam int CTL_CHK = 6;
   localparam int CTL_VREV = 7;
   localparam int CFG_EN = 0;
   localparam int CFG_B18 = 1;
   localparam int CFG_GINV = 2;
   localparam int CFG_INT = 3;
   localparam int CFG_OSC = 4;
   localparam int CFG_SCROLL = 5;
   localparam logic [4:0] P_WHITE = 5'h01;
   localparam logic [4:0] P_BLACK = 5'h02;
   localparam logic [4:0] P_RED = 5'h03;
   localparam logic [4:0] P_GREEN = 5'h04;
   localparam logic [4:0] P_BLUE = 5'h05;
   localparam logic [4:0] P_HR_W = 5'h06;
   localparam logic [4:0] P_HR_R = 5'h07;
   localparam logic [4:0] P_HR_G = 5'h08;
   localparam logic [4:0] P_HR_B = 5'h09;
   localparam logic [4:0] P_VR_W = 5'h0A;
   localparam logic [4:0] P_VR_R = 5'h0B;
   localparam logic [4:0] P_VR_G = 5'h0C;
   localparam logic [4:0] P_VR_B = 5'h0D;
   localparam logic [4:0] P_CUSTOM = 5'h0E;
   localparam logic [4:0] P_CHECK = 5'h0F;
   localparam logic [4:0] P_VCOM = 5'h10;
   localparam logic [4:0] P_BARS = 5'h11;
   localparam logic [7:0] RST_CTL = 8'h01;
   localparam logic [7:0] RST_SCR_FRAMES = 8'h3C;
   localparam logic [7:0] RST_SCR_COUNT = 8'h0F;
   localparam logic [11:0] RST_HACT = 12'h280;
   localparam logic [11:0] RST_HTOT = 12'h320;
   localparam logic [11:0] RST_VACT = 12'h1E0;
   localparam logic [11:0] RST_VTOT = 12'h20D;
   localparam logic [11:0] SYNC_H_LEN = 12'h008;
   localparam logic [11:0] SYNC_V_LEN = 12'h002;
   localparam int CHECK_BIT = 5;
   localparam logic [12:0] RAMP_STEP = 13'h00FF;
   localparam logic [23:0] MASK_18 = 24'hFCFCFC;
   localparam logic [23:0] ALL_ON = 24'hFFFFFF;
   localparam int CLK_PERIOD_NS = 4;
   localparam int OSC_PERIOD_NS = 20;
   localparam int OSC_DIV_DEF = OSC_PERIOD_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic de;
      logic hs;
      logic vs;
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } vtpg_pixel_type;

   function automatic logic [7:0] ind_reset(input logic [4:0] i);
      logic [2:0] k;
      k = i[2:0];
      case (i)
         IX_CTL: return RST_CTL;
         IX_SCR_FRAMES: return RST_SCR_FRAMES;
         IX_SCR_COUNT: return RST_SCR_COUNT;
         IX_HACT: return RST_HACT[7:0];
         IX_HACT + 5'h01: return {4'h0, RST_HACT[11:8]};
         IX_HTOT: return RST_HTOT[7:0];
         IX_HTOT + 5'h01: return {4'h0, RST_HTOT[11:8]};
         IX_VACT: return RST_VACT[7:0];
         IX_VACT + 5'h01: return {4'h0, RST_VACT[11:8]};
         IX_VTOT: return RST_VTOT[7:0];
         IX_VTOT + 5'h01: return {4'h0, RST_VTOT[11:8]};
         default: begin
            // identity scroll order: slot n shows pattern n+1
            if (i[4:3] == IX_ORDER[4:3]) return {k, 1'b1, k, 1'b0};
            return 8'h00;
         end
      endcase
   endfunction
endpackage
`default_nettype wire

// File: core/vtpg_sync.sv
/*
 * vtpg_sync: two-flop synchroniser for a bundle of pin inputs.
 * Assumes each bit is sampled independently; buses are qualified later.
 */
`default_nettype none
module vtpg_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// File: core/vtpg_fifo.sv
/*
 * vtpg_fifo: synchronous valid/ready FIFO, width and depth as parameters.
 * Assumes DEPTH is a power of two; one push and one pop per cycle at most.
 */
`default_nettype none
module vtpg_fifo #(
   parameter int WIDTH = 27,
   parameter int DEPTH = 32
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: core/vtpg_top.sv
/*
 * vtpg_top: video test pattern generator with external or internal frame
 * timing, auto-scroll, colour modes, indirect register window and an output
 * FIFO toward the serial link payload.
 * Assumes video pins are asynchronous to core_clk and the pixel clock pin
 * runs well below half of core_clk; register port is synchronous.
 */
`default_nettype none
// Function
// - pattern shown whenever enabled and powered; without video only in internal oscillator timing
// - oscillator tick can replace missing pixel clock
// - seventeen pattern types available
// - per-pattern inversion control bit
// - pattern 14: custom red/green/blue fill
// - pattern 15: checkerboard, optional custom colour
// - pattern 16: VCOM stripes, colour order reversible
// - pattern 17: eight bars, never auto-scrolled
// - scroll off: static select field chooses
// - scroll on: up to sixteen programmed entries
// - 18-bit mode zeroes two low bits
// - external timing after reset, internal optional
// - long blank beyond twice line means vblank
// - external syncs forwarded, two pixel delay
// - measure frame size, scale ramps
// - internal timing from programmed totals
// - global invert flips every generated colour bit, before the 18-bit mask
// - indirect address 0x66, data 0x67
module vtpg_top
   import vtpg_pkg::*;
#(
   parameter int OSC_DIV = vtpg_pkg::OSC_DIV_DEF,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic power_down,
   input wire logic pix_clk_in,
   input wire logic active_video_flag_in,
   input wire logic horizontal_sync_in,
   input wire logic vertical_sync_in,
   input wire logic [23:0] rgb_in,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output vtpg_pkg::vtpg_pixel_type link_data,
   output logic link_valid,
   input wire logic link_ready,
   output logic gen_active,
   output logic [11:0] meas_width,
   output logic [11:0] meas_height
);
   import vtpg_pkg::*;

   logic [7:0] ind [IND_RW_DEPTH];
   logic [7:0] ind_addr;
   logic [7:0] ind_rd;
   logic [27:0] sync_q;
   logic s_pclk, pclk_d, ext_edge;
   logic [15:0] osc_cnt;
   logic osc_tick, tick, fifo_in_ready;
   logic [7:0] ctl, cfg;
   logic int_tim, osc_sel, active, scroll;
   vtpg_pixel_type st1, out_pix;
   logic out_valid;
   logic cur_de, cur_hs, cur_vs, prev_de, prev_vs;
   logic de_fall, frame_start, vblank_long;
   logic [11:0] x, y, hcnt, vcnt;
   logic [11:0] hact, htot, vact, vtot, width, height;
   logic int_de, int_hs, int_vs;
   logic [12:0] blank_run, hacc, vacc, hstep, vstep;
   logic [7:0] hlev, vlev, slot_byte, fcnt;
   logic [3:0] slot, nib;
   logic [4:0] sel;
   logic [23:0] base, pix_rgb, cust;

   function automatic logic [11:0] tim12(input logic [4:0] ix);
      return {ind[ix + 5'h01][3:0], ind[ix]};
   endfunction

   assign ctl = ind[IX_CTL];
   assign cfg = ind[IX_CFG];
   assign int_tim = cfg[CFG_INT];
   assign osc_sel = cfg[CFG_OSC];
   assign scroll = cfg[CFG_SCROLL];
   assign active = cfg[CFG_EN] & ~power_down;
   assign gen_active = active;
   assign cust = {ind[IX_RED], ind[IX_GRN], ind[IX_BLU]};
   assign hact = tim12(IX_HACT);
   assign htot = tim12(IX_HTOT);
   assign vact = tim12(IX_VACT);
   assign vtot = tim12(IX_VTOT);

   // register window: only two direct addresses, all settings behind them
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ind_addr <= 8'h00;
      end else if (reg_wr && reg_addr == REG_IND_ADDR) begin
         ind_addr <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < IND_RW_DEPTH; i++) begin
            ind[i] <= ind_reset(5'(i));
         end
      end else if (reg_wr && reg_addr == REG_IND_DATA && ind_addr < 8'(IND_RW_DEPTH)) begin
         ind[ind_addr[4:0]] <= reg_wdata;
      end
   end

   always_comb begin
      ind_rd = 8'h00;
      if (ind_addr < 8'(IND_RW_DEPTH)) begin
         ind_rd = ind[ind_addr[4:0]];
      end else if (ind_addr[7:5] == 3'h0) begin
         case (ind_addr[4:0])
            IX_ST_WL: ind_rd = meas_width[7:0];
            IX_ST_WH: ind_rd = {4'h0, meas_width[11:8]};
            IX_ST_HL: ind_rd = meas_height[7:0];
            IX_ST_HH: ind_rd = {4'h0, meas_height[11:8]};
            IX_ST_SLOT: ind_rd = {3'h0, sel};
            default: ind_rd = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_IND_ADDR: reg_rdata <= ind_addr;
            REG_IND_DATA: reg_rdata <= ind_rd;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   vtpg_sync #(.WIDTH(28)) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .d({pix_clk_in, active_video_flag_in, horizontal_sync_in, vertical_sync_in, rgb_in}),
      .q(sync_q)
   );
   assign s_pclk = sync_q[27];

   // pixel rate as an enable: pin clock edge or divided oscillator
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pclk_d <= 1'b0;
      end else begin
         pclk_d <= s_pclk;
      end
   end
   assign ext_edge = s_pclk & ~pclk_d;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         osc_cnt <= 16'h0000;
         osc_tick <= 1'b0;
      end else begin
         osc_tick <= (osc_cnt == 16'(OSC_DIV - 1));
         osc_cnt <= (osc_cnt == 16'(OSC_DIV - 1)) ? 16'h0000 : osc_cnt + 16'h0001;
      end
   end
   // a full fifo stalls the pixel rate; in external timing that drops input
   assign tick = (int_tim && osc_sel ? osc_tick : ext_edge) & fifo_in_ready;

   // first pixel stage of the incoming video
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st1 <= '0;
      end else if (tick) begin
         st1 <= sync_q[26:0];
      end
   end

   // internal frame timing
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         hcnt <= 12'h000;
         vcnt <= 12'h000;
      end else if (tick) begin
         if (hcnt + 12'h001 >= htot) begin
            hcnt <= 12'h000;
            vcnt <= (vcnt + 12'h001 >= vtot) ? 12'h000 : vcnt + 12'h001;
         end else begin
            hcnt <= hcnt + 12'h001;
         end
      end
   end
   assign int_de = (hcnt < hact) && (vcnt < vact);
   assign int_hs = (hcnt >= hact) && (hcnt < hact + SYNC_H_LEN);
   assign int_vs = (vcnt >= vact) && (vcnt < vact + SYNC_V_LEN);

   assign cur_de = int_tim ? int_de : st1.de;
   assign cur_hs = int_tim ? int_hs : st1.hs;
   assign cur_vs = int_tim ? int_vs : st1.vs;
   assign de_fall = prev_de & ~cur_de;
   assign vblank_long = ~cur_de && (blank_run == 13'({meas_width, 1'b0}) + 13'h0001) &&
                        (meas_width != 12'h000);
   assign frame_start = int_tim ? (hcnt == 12'h000 && vcnt == 12'h000)
                                : ((cur_vs & ~prev_vs) | vblank_long);

   // position, line length and frame height measurement
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prev_de <= 1'b0;
         prev_vs <= 1'b0;
         x <= 12'h000;
         y <= 12'h000;
         blank_run <= 13'h0000;
         meas_width <= 12'h000;
         meas_height <= 12'h000;
      end else if (tick) begin
         prev_de <= cur_de;
         prev_vs <= cur_vs;
         x <= cur_de ? x + 12'h001 : 12'h000;
         if (cur_de) begin
            blank_run <= 13'h0000;
         end else if (blank_run != 13'h1FFF) begin
            blank_run <= blank_run + 13'h0001;
         end
         if (de_fall) begin
            meas_width <= x;
         end
         if (frame_start) begin
            y <= 12'h000;
            if (y != 12'h000) begin
               meas_height <= y;
            end
         end else if (de_fall) begin
            y <= y + 12'h001;
         end
      end
   end

   // horizontal ramp steps 255/width per pixel, vertical 255/height per line; widths below 255 rise one level per pixel and end short of 255
   assign width = int_tim ? hact : meas_width;
   assign height = int_tim ? vact : meas_height;
   assign hstep = hacc + RAMP_STEP;
   assign vstep = vacc + RAMP_STEP;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         hacc <= 13'h0000;
         hlev <= 8'h00;
      end else if (tick) begin
         if (!cur_de) begin
            hacc <= 13'h0000;
            hlev <= 8'h00;
         end else if (hstep >= {1'b0, width}) begin
            hacc <= hstep - {1'b0, width};
            hlev <= hlev + 8'h01;
         end else begin
            hacc <= hstep;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         vacc <= 13'h0000;
         vlev <= 8'h00;
      end else if (tick) begin
         if (frame_start) begin
            vacc <= 13'h0000;
            vlev <= 8'h00;
         end else if (de_fall) begin
            if (vstep >= {1'b0, height}) begin
               vacc <= vstep - {1'b0, height};
               vlev <= vlev + 8'h01;
            end else begin
               vacc <= vstep;
            end
         end
      end
   end

   // auto-scroll: slot nibbles hold pattern-1, so bars can never appear
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         slot <= 4'h0;
         fcnt <= 8'h00;
      end else if (!scroll) begin
         slot <= 4'h0;
         fcnt <= 8'h00;
      end else if (tick && frame_start) begin
         if (fcnt >= ind[IX_SCR_FRAMES]) begin
            fcnt <= 8'h00;
            slot <= (slot >= ind[IX_SCR_COUNT][3:0]) ? 4'h0 : slot + 4'h1;
         end else begin
            fcnt <= fcnt + 8'h01;
         end
      end
   end
   assign slot_byte = ind[IX_ORDER + 5'(slot[3:1])];
   assign nib = slot[0] ? slot_byte[7:4] : slot_byte[3:0];
   assign sel = scroll ? 5'(nib) + 5'h01 : ctl[4:0];

   always_comb begin
      base = 24'h000000;
      case (sel)
         P_WHITE: base = ALL_ON;
         P_BLACK: base = 24'h000000;
         P_RED: base = 24'hFF0000;
         P_GREEN: base = 24'h00FF00;
         P_BLUE: base = 24'h0000FF;
         P_HR_W: base = {hlev, hlev, hlev};
         P_HR_R: base = {hlev, 16'h0000};
         P_HR_G: base = {8'h00, hlev, 8'h00};
         P_HR_B: base = {16'h0000, hlev};
         P_VR_W: base = {vlev, vlev, vlev};
         P_VR_R: base = {vlev, 16'h0000};
         P_VR_G: base = {8'h00, vlev, 8'h00};
         P_VR_B: base = {16'h0000, vlev};
         P_CUSTOM: base = cust;
         P_CHECK: begin
            if (x[CHECK_BIT] ^ y[CHECK_BIT]) begin
               base = ctl[CTL_CHK] ? cust : ALL_ON;
            end
         end
         P_VCOM: begin
            case (x[1:0] ^ {2{ctl[CTL_VREV]}})
               2'h0: base = 24'hFFFF00;
               2'h1: base = 24'h00FFFF;
               2'h2: base = 24'h0000FF;
               default: base = 24'hFF0000;
            endcase
         end
         P_BARS: begin
            case (hlev[7:5])
               3'h0: base = ALL_ON;
               3'h1: base = 24'hFFFF00;
               3'h2: base = 24'h00FFFF;
               3'h3: base = 24'h00FF00;
               3'h4: base = 24'hFF00FF;
               3'h5: base = 24'hFF0000;
               3'h6: base = 24'h0000FF;
               default: base = 24'h000000;
            endcase
         end
         default: base = 24'h000000;
      endcase
      pix_rgb = base ^ {24{ctl[CTL_INV] ^ cfg[CFG_GINV]}};
      pix_rgb = pix_rgb & (cfg[CFG_B18] ? MASK_18 : ALL_ON);
   end

   // second pixel stage: generated frame or the delayed input
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         out_pix <= '0;
         out_valid <= 1'b0;
      end else begin
         out_valid <= tick;
         if (tick) begin
            if (active) begin
               out_pix <= {cur_de, cur_hs, cur_vs, cur_de ? pix_rgb : 24'h000000};
            end else begin
               out_pix <= st1;
            end
         end
      end
   end

   vtpg_fifo #(.WIDTH($bits(vtpg_pixel_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .in_valid(out_valid),
      .in_ready(fifo_in_ready),
      .in_data(out_pix),
      .out_valid(link_valid),
      .out_ready(link_ready),
      .out_data(link_data)
   );

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   property p_reset_ext;
      $past(sys_rst) |-> !int_tim && !active && sel == P_WHITE;
   endproperty
   a_reset_ext: assert property (p_reset_ext) else $error("not external timing after reset");

   property p_b18;
      out_valid && $past(active && cfg[CFG_B18]) |-> out_pix.r[1:0] == 2'h0 && out_pix.b[1:0] == 2'h0;
   endproperty
   a_b18: assert property (p_b18) else $error("low colour bits set in 18-bit mode");

   property p_ginv;
      tick && active && cur_de && sel == P_BLACK && cfg[CFG_GINV] && !ctl[CTL_INV] && !cfg[CFG_B18]
         |=> out_pix.r == 8'hFF && out_pix.g == 8'hFF && out_pix.b == 8'hFF;
   endproperty
   a_ginv: assert property (p_ginv) else $error("global invert missing");

   property p_custom;
      tick && active && cur_de && sel == P_CUSTOM && !ctl[CTL_INV] && !cfg[CFG_GINV] && !cfg[CFG_B18]
         |=> {out_pix.r, out_pix.g, out_pix.b} == $past(cust);
   endproperty
   a_custom: assert property (p_custom) else $error("custom colour wrong");

   property p_scroll_bars;
      scroll |-> sel != P_BARS && sel != 5'h00;
   endproperty
   a_scroll_bars: assert property (p_scroll_bars) else $error("bars chosen by scroll");

   property p_static;
      !scroll |-> sel == ctl[4:0];
   endproperty
   a_static: assert property (p_static) else $error("static select ignored");

   property p_osc;
      int_tim && osc_sel && osc_tick && fifo_in_ready |-> tick;
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator tick lost");

   property p_vblank;
      tick && !int_tim && vblank_long |=> y == 12'h000 && vlev == 8'h00;
   endproperty
   a_vblank: assert property (p_vblank) else $error("long blank not taken as vblank");

   property p_pass;
      tick && !active |=> out_valid && out_pix == $past(st1);
   endproperty
   a_pass: assert property (p_pass) else $error("input not forwarded when idle");

   sequence s_set_addr;
      reg_wr && reg_addr == REG_IND_ADDR && reg_wdata < 8'(IND_RW_DEPTH);
   endsequence
   sequence s_write_data;
      reg_wr && reg_addr == REG_IND_DATA && ind_addr < 8'(IND_RW_DEPTH);
   endsequence
   property p_indirect;
      s_set_addr ##[1:2] s_write_data |=> ind[ind_addr[4:0]] == $past(reg_wdata);
   endproperty
   a_indirect: assert property (p_indirect) else $error("indirect write lost");
endmodule
`default_nettype wire

// File: verif/vtpg_panel.sv
/* vtpg_panel: link sink standing in for the far panel, records pops.
   Assumes the testbench owns the stall input. */
`default_nettype none
module vtpg_panel
   import vtpg_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic stall,
   input wire vtpg_pkg::vtpg_pixel_type link_data,
   input wire logic link_valid,
   output logic link_ready,
   output logic [23:0] last_rgb,
   output int pops
);
   // slow answers come from stall, not from a fixed ready
   assign link_ready = ~stall;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pops <= 0;
         last_rgb <= 24'h000000;
      end else if (link_valid && link_ready) begin
         pops <= pops + 1;
         if (link_data.de) last_rgb <= {link_data.r, link_data.g, link_data.b};
      end
   end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
/* tb_top: table-driven bench for the pattern generator.
   Assumes vtpg_panel as link sink and the package's indirect map. */
`default_nettype none
module tb_top
   import vtpg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] ri [7] = '{IX_CTL, IX_SCR_FRAMES, IX_SCR_COUNT, IX_HACT, IX_HACT + 5'h01, IX_ORDER,
      IX_VTOT};
   localparam logic [7:0] rv [7] = '{RST_CTL, RST_SCR_FRAMES, RST_SCR_COUNT, RST_HACT[7:0], {4'h0, RST_HACT[11:8]},
      8'h10, RST_VTOT[7:0]};
   localparam logic [7:0] pc [12] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h0E, 8'h0E, 8'h2E, 8'h0E, 8'h03,
      8'h02, 8'h03};
   localparam logic [7:0] pf [12] = '{8'h00, 8'h01, 8'h19, 8'h19, 8'h19, 8'h19, 8'h1B, 8'h19, 8'h1D, 8'h1D,
      8'h1D, 8'h39};
   localparam logic [23:0] pe [12] = '{24'hABCDEF, 24'hFFFFFF, 24'hFFFFFF, 24'h000000, 24'hFF0000, 24'h123456,
      24'h103454, 24'hEDCBA9, 24'hEDCBA9, 24'h00FFFF, 24'hFFFFFF, 24'hFFFFFF};
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic power_down = 1'b0;
   logic pix_clk_in = 1'b0;
   logic de_pin = 1'b0;
   logic [11:0] meas_width;
   logic [11:0] meas_height;
   logic stall = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   vtpg_pixel_type link_data;
   logic link_valid;
   logic link_ready;
   logic gen_active;
   logic [23:0] last_rgb;
   logic [7:0] rd;
   int pops;
   int p0;
   int i;
   int cyc = 0;
   int errors = 0;
   int check_count = 0;
   vtpg_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .power_down(power_down), .pix_clk_in(pix_clk_in),
      .active_video_flag_in(de_pin), .horizontal_sync_in(1'b0), .vertical_sync_in(1'b0), .rgb_in(24'hABCDEF),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .link_data(link_data), .link_valid(link_valid), .link_ready(link_ready), .gen_active(gen_active),
      .meas_width(meas_width), .meas_height(meas_height));
   vtpg_panel panel (.core_clk(core_clk), .sys_rst(sys_rst), .stall(stall), .link_data(link_data),
      .link_valid(link_valid), .link_ready(link_ready), .last_rgb(last_rgb), .pops(pops));
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   task automatic test_done();
      if (errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask
   task automatic reg_w(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic ind_w(input logic [4:0] x, input logic [7:0] d);
      reg_w(REG_IND_ADDR, {3'h0, x});
      reg_w(REG_IND_DATA, d);
   endtask
   task automatic ind_r(input logic [4:0] x, output logic [7:0] d);
      reg_w(REG_IND_ADDR, {3'h0, x});
      rd_reg(REG_IND_DATA, d);
   endtask
   // slow pixel clock, well under half the core rate; doubles as hang guard
   always @(negedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 0) pix_clk_in <= ~pix_clk_in;
      // 12 of 20 pixels active, 10 of 12 lines: long blank, no vertical sync
      if (cyc % 8 == 4) de_pin <= ((cyc + 4) / 8 % 20 < 12) && ((cyc + 4) / 160 % 12 < 10);
      if (cyc > 40000) begin
         errors++;
         test_done();
      end
   end
   initial begin
      repeat (16) @(negedge core_clk);
      sys_rst = 1'b0;
      chk("gen_active", 24'h0, {23'h0, gen_active});
      for (i = 0; i < 7; i++) begin
         ind_r(ri[i], rd);
         chk("indirect", {16'h0, rv[i]}, {16'h0, rd});
      end
      rd_reg(8'h65, rd);
      chk("unmapped", 24'h0, {16'h0, rd});
      ind_w(IX_RED, 8'h12);
      ind_w(IX_GRN, 8'h34);
      ind_w(IX_BLU, 8'h56);
      ind_r(IX_RED, rd);
      chk("red", 24'h12, {16'h0, rd});
      // rows: passthrough, external, then internal oscillator timing
      for (i = 0; i < 12; i++) begin
         ind_w(IX_CTL, pc[i]);
         ind_w(IX_CFG, pf[i]);
         repeat (1200) @(negedge core_clk);
         chk("pixel", pe[i], last_rgb);
         if (i == 1) begin
            chk("meas_width", 24'h00000C, {12'h000, meas_width});
            chk("meas_height", 24'h00000A, {12'h000, meas_height});
         end
      end
      ind_r(IX_ST_SLOT, rd);
      chk("slot", 24'(P_WHITE), {16'h0, rd});
      chk("gen_active", 24'h1, {23'h0, gen_active});
      power_down = 1'b1;
      @(negedge core_clk);
      chk("gen_active", 24'h0, {23'h0, gen_active});
      power_down = 1'b0;
      // fill until refused, then drain one word per cycle
      stall = 1'b1;
      repeat (400) @(negedge core_clk);
      chk("link_valid", 24'h1, {23'h0, link_valid});
      p0 = pops;
      stall = 1'b0;
      repeat (32) @(negedge core_clk);
      chk("drained", 24'h000020, 24'(pops - p0));
      test_done();
   end
endmodule
`default_nettype wire
